/* flash_pkg.sv */
// Purpose: Shared constants for the serial flash device end and its host end
// Assumes: 25 MHz system clock on both ends
// Notes: Self-timed durations are plain defaults, given in ns
package flash_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int CLK_NS = 40;
    localparam int PAGE_COUNT = 512;
    localparam int PAGE_STRIDE = 264;
    localparam int BLOCK_PAGES = 8;
    localparam int MEM_BYTES = PAGE_COUNT * PAGE_STRIDE;
    localparam logic [8:0] LAST_INDEX_264 = 9'h107;
    localparam logic [8:0] LAST_INDEX_256 = 9'h0FF;
    localparam int PAGE_LSB_264 = 9;
    localparam int PAGE_LSB_256 = 8;
    localparam int BLOCK_LSB_264 = 12;
    localparam int BLOCK_LSB_256 = 11;
    localparam int BLOCK_SHIFT = 3;
    localparam logic [11:0] PAGE_WALK = 12'h108;
    localparam logic [11:0] BLOCK_WALK = 12'h840;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // ----------------------------------------
    // Opcodes and frame layout
    // ----------------------------------------
    localparam logic [7:0] OP_PAGE_READ = 8'hD2;
    localparam logic [7:0] OP_BUF_READ_HI = 8'hD4;
    localparam logic [7:0] OP_BUF_READ_LO = 8'hD1;
    localparam logic [7:0] OP_BUF_WRITE = 8'h84;
    localparam logic [7:0] OP_PROG_ERASE = 8'h83;
    localparam logic [7:0] OP_PROG = 8'h88;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
    localparam logic [3:0] BYTE_OPCODE = 4'h0;
    localparam logic [3:0] BYTE_ADDR_LAST = 4'h3;
    localparam logic [3:0] BYTE_DATA_FIRST = 4'h4;
    localparam logic [3:0] BYTE_COUNT_MAX = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] BUF_READ_DUMMY = 4'h1;
    localparam logic [3:0] PAGE_READ_DUMMY = 4'h4;
    // ----------------------------------------
    // Self-timed durations
    // ----------------------------------------
    localparam int ERASE_PROGRAM_TIME_MAX_NS = 40000;
    localparam int PROGRAM_TIME_MAX_NS = 20000;
    localparam int PAGE_ERASE_TIME_MAX_NS = 30000;
    localparam int BLOCK_ERASE_TIME_MAX_NS = 60000;
    localparam logic [11:0] EP_CYCLES = 12'(ERASE_PROGRAM_TIME_MAX_NS / CLK_NS);
    localparam logic [11:0] P_CYCLES = 12'(PROGRAM_TIME_MAX_NS / CLK_NS);
    localparam logic [11:0] PE_CYCLES = 12'(PAGE_ERASE_TIME_MAX_NS / CLK_NS);
    localparam logic [11:0] BE_CYCLES = 12'(BLOCK_ERASE_TIME_MAX_NS / CLK_NS);
    // ----------------------------------------
    // Host serial clock divider
    // ----------------------------------------
    localparam logic [2:0] PH_RISE = 3'h3;
    localparam logic [2:0] PH_LAST = 3'h7;
    localparam logic [2:0] CS_GAP = 3'h7;

    function automatic logic [3:0] dummy_bytes(input logic [7:0] op);
        if (op == OP_PAGE_READ) begin
            return PAGE_READ_DUMMY;
        end
        if (op == OP_BUF_READ_HI || op == OP_BUF_READ_LO) begin
            return BUF_READ_DUMMY;
        end
        return 4'h0;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return op == OP_PAGE_READ || op == OP_BUF_READ_HI || op == OP_BUF_READ_LO;
    endfunction
endpackage

/* flash_link_if.sv */
// Purpose: Serial pins between the flash device end and the host end
// Assumes: Host makes chip select and serial clock
// Notes: Serial output idles high when undriven
`timescale 1ns/1ns
interface flash_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    assign so_line = so_oe ? so : 1'b1;

    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so_line);
endinterface

/* edge_sync.sv */
// Purpose: Two-flop synchroniser with edge detection
// Assumes: Input is asynchronous to clock_in
// Notes: Edges come from the second and third flops only
`timescale 1ns/1ns
module edge_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic async_in,
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            last_q <= RESET_LEVEL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~last_q;
    assign fall_out = ~sync_q & last_q;
endmodule

/* flash_device.sv */
// Purpose: Serial flash device end: buffer, page read, program and erase
// Assumes: Mode 0 framing; link pins sampled by clock_in through two flops
// Notes: Serial clock must be slower than a quarter of clock_in
`timescale 1ns/1ns
module flash_device (
    input wire logic clock_in,
    input wire logic reset_in,
    flash_link_if.dev link,
    input wire logic page_256_in,
    output logic busy_out
);
    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    logic cs_n_s;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic si_s;

    edge_sync #(.RESET_LEVEL(1'b1)) cs_sync (
        .clock_in(clock_in), .reset_in(reset_in), .async_in(link.cs_n),
        .level_out(cs_n_s), .rise_out(cs_rise), .fall_out(cs_fall)
    );
    edge_sync #(.RESET_LEVEL(1'b0)) sck_sync (
        .clock_in(clock_in), .reset_in(reset_in), .async_in(link.sck),
        .level_out(), .rise_out(sck_rise), .fall_out(sck_fall)
    );
    edge_sync #(.RESET_LEVEL(1'b0)) si_sync (
        .clock_in(clock_in), .reset_in(reset_in), .async_in(link.si),
        .level_out(si_s), .rise_out(), .fall_out()
    );

    // ----------------------------------------
    // Address decoding
    // ----------------------------------------
    function automatic logic [8:0] page_of(input logic [23:0] a, input logic p256);
        return p256 ? 9'(a >> flash_pkg::PAGE_LSB_256) : 9'(a >> flash_pkg::PAGE_LSB_264);
    endfunction

    function automatic logic [8:0] index_of(input logic [23:0] a, input logic p256);
        return p256 ? {1'b0, a[7:0]} : a[8:0];
    endfunction

    function automatic logic [8:0] next_index(input logic [8:0] i, input logic p256);
        logic [8:0] last;
        last = p256 ? flash_pkg::LAST_INDEX_256 : flash_pkg::LAST_INDEX_264;
        return (i == last) ? 9'h000 : 9'(i + 9'h001);
    endfunction

    function automatic logic [17:0] mem_addr(input logic [8:0] page, input logic [8:0] i);
        return 18'(int'(page) * flash_pkg::PAGE_STRIDE + int'(i));
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] buffer_mem [0:flash_pkg::PAGE_STRIDE-1];
    logic [7:0] array_mem [0:flash_pkg::MEM_BYTES-1];

    // ----------------------------------------
    // Frame receive
    // ----------------------------------------
    logic [7:0] sr_q;
    logic [2:0] bit_cnt_q;
    logic [3:0] byte_cnt_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic [8:0] page_q;
    logic [8:0] index_q;
    logic [7:0] rx_byte;
    logic byte_done;
    logic [23:0] addr_full;
    logic [3:0] data_start;
    logic busy;

    assign rx_byte = {sr_q[6:0], si_s};
    assign byte_done = sck_rise && !cs_n_s && bit_cnt_q == flash_pkg::BIT_LAST;
    assign addr_full = {addr_q[15:0], rx_byte};
    assign data_start = 4'(flash_pkg::BYTE_ADDR_LAST + flash_pkg::dummy_bytes(opcode_q));

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sr_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 4'h0;
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (cs_fall) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 4'h0;
        end else if (sck_rise && !cs_n_s) begin
            sr_q <= rx_byte;
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            if (byte_done) begin
                if (byte_cnt_q != flash_pkg::BYTE_COUNT_MAX) begin
                    byte_cnt_q <= 4'(byte_cnt_q + 4'h1);
                end
                if (byte_cnt_q == flash_pkg::BYTE_OPCODE) begin
                    opcode_q <= rx_byte;
                end else if (byte_cnt_q <= flash_pkg::BYTE_ADDR_LAST) begin
                    addr_q <= addr_full;
                end
            end
        end
    end

    // ----------------------------------------
    // Data pointer, buffer write, read shifter
    // ----------------------------------------
    logic [7:0] tx_q;
    logic so_q;
    logic so_oe_q;
    logic is_page_read;
    logic is_buf_read;

    assign is_page_read = opcode_q == flash_pkg::OP_PAGE_READ;
    assign is_buf_read = opcode_q == flash_pkg::OP_BUF_READ_HI
        || opcode_q == flash_pkg::OP_BUF_READ_LO;

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            page_q <= 9'h000;
            index_q <= 9'h000;
        end else if (byte_done && byte_cnt_q == flash_pkg::BYTE_ADDR_LAST) begin
            page_q <= page_of(addr_full, page_256_in);
            index_q <= index_of(addr_full, page_256_in);
        end else if (byte_done && byte_cnt_q >= data_start
            && (is_page_read || is_buf_read || opcode_q == flash_pkg::OP_BUF_WRITE)) begin
            // Wrap stays inside the page or buffer
            index_q <= next_index(index_q, page_256_in);
        end
    end

    always_ff @(posedge clock_in) begin
        // Writes only while select is low, refused when busy
        if (byte_done && byte_cnt_q >= flash_pkg::BYTE_DATA_FIRST
            && opcode_q == flash_pkg::OP_BUF_WRITE && !busy) begin
            buffer_mem[index_q] <= rx_byte;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            tx_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else if (cs_rise || cs_fall) begin
            so_oe_q <= 1'b0;
        end else if (byte_done && byte_cnt_q >= data_start && is_page_read) begin
            tx_q <= array_mem[mem_addr(page_q, index_q)];
            so_oe_q <= 1'b1;
        end else if (byte_done && byte_cnt_q >= data_start && is_buf_read) begin
            tx_q <= buffer_mem[index_q];
            so_oe_q <= 1'b1;
        end else if (sck_fall && so_oe_q) begin
            so_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign link.so = so_q;
    assign link.so_oe = so_oe_q;

    // ----------------------------------------
    // Self-timed sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {SQ_IDLE, SQ_ERASE, SQ_PROG, SQ_WAIT} seq_state_t;
    seq_state_t state_q;
    logic [7:0] seq_op_q;
    logic [17:0] base_q;
    logic [11:0] walk_q;
    logic [11:0] walk_end_q;
    logic [11:0] wait_q;
    logic start;
    logic [5:0] block;

    assign busy = state_q != SQ_IDLE;
    assign busy_out = busy;
    assign block = page_256_in ? 6'(addr_q >> flash_pkg::BLOCK_LSB_256)
        : 6'(addr_q >> flash_pkg::BLOCK_LSB_264);
    assign start = cs_rise && !busy && byte_cnt_q >= flash_pkg::BYTE_DATA_FIRST
        && (opcode_q == flash_pkg::OP_PROG_ERASE || opcode_q == flash_pkg::OP_PROG
        || opcode_q == flash_pkg::OP_PAGE_ERASE || opcode_q == flash_pkg::OP_BLOCK_ERASE);

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= SQ_IDLE;
            seq_op_q <= 8'h00;
            base_q <= 18'h00000;
            walk_q <= 12'h000;
            walk_end_q <= 12'h000;
            wait_q <= 12'h000;
        end else begin
            case (state_q)
                SQ_IDLE: begin
                    if (start) begin
                        seq_op_q <= opcode_q;
                        walk_q <= 12'h000;
                        if (opcode_q == flash_pkg::OP_BLOCK_ERASE) begin
                            base_q <= mem_addr(9'({block, 3'h0}), 9'h000);
                            walk_end_q <= flash_pkg::BLOCK_WALK;
                            wait_q <= flash_pkg::BE_CYCLES;
                        end else begin
                            base_q <= mem_addr(page_of(addr_q, page_256_in), 9'h000);
                            walk_end_q <= flash_pkg::PAGE_WALK;
                            wait_q <= (opcode_q == flash_pkg::OP_PROG_ERASE) ? flash_pkg::EP_CYCLES
                                : (opcode_q == flash_pkg::OP_PROG) ? flash_pkg::P_CYCLES
                                : flash_pkg::PE_CYCLES;
                        end
                        // Program-only relies on the host erasing first
                        state_q <= (opcode_q == flash_pkg::OP_PROG) ? SQ_PROG : SQ_ERASE;
                    end
                end
                SQ_ERASE: begin
                    walk_q <= 12'(walk_q + 12'h001);
                    if (12'(walk_q + 12'h001) == walk_end_q) begin
                        walk_q <= 12'h000;
                        state_q <= (seq_op_q == flash_pkg::OP_PROG_ERASE) ? SQ_PROG : SQ_WAIT;
                    end
                end
                SQ_PROG: begin
                    walk_q <= 12'(walk_q + 12'h001);
                    if (12'(walk_q + 12'h001) == walk_end_q) begin
                        state_q <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    // Busy drops only when the timed window closes
                    wait_q <= 12'(wait_q - 12'h001);
                    if (wait_q <= 12'h001) begin
                        state_q <= SQ_IDLE;
                    end
                end
                default: begin
                    state_q <= SQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (state_q == SQ_ERASE) begin
            array_mem[18'(base_q + 18'(walk_q))] <= flash_pkg::ERASED_BYTE;
        end else if (state_q == SQ_PROG) begin
            // Programming only clears bits, as the cells do
            array_mem[18'(base_q + 18'(walk_q))] <= array_mem[18'(base_q + 18'(walk_q))]
                & buffer_mem[9'(walk_q)];
        end
    end
endmodule

/* flash_host.sv */
// Purpose: Host end: frames one command on the serial link per start pulse
// Assumes: Serial clock is clock_in divided by eight
// Notes: Output bits are sampled late in the high phase to cover sync delay
`timescale 1ns/1ns
module flash_host (
    input wire logic clock_in,
    input wire logic reset_in,
    flash_link_if.host link,
    input wire logic start_in,
    input wire logic [7:0] opcode_in,
    input wire logic [23:0] address_in,
    input wire logic [9:0] length_in,
    input wire logic [7:0] wdata_in,
    output logic wdata_take_out,
    output logic [7:0] rdata_out,
    output logic rdata_valid_out,
    output logic busy_out
);
    // ----------------------------------------
    // Sampling and state
    // ----------------------------------------
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
    host_state_t state_q;
    logic so_s;
    logic cs_n_q;
    logic sck_q;
    logic si_q;
    logic [2:0] ph_q;
    logic [2:0] bit_q;
    logic [10:0] byte_q;
    logic [10:0] total_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic [10:0] next_byte;
    logic [10:0] data_first;
    logic [7:0] next_tx;

    edge_sync #(.RESET_LEVEL(1'b1)) so_sync (
        .clock_in(clock_in), .reset_in(reset_in), .async_in(link.so_line),
        .level_out(so_s), .rise_out(), .fall_out()
    );

    assign next_byte = 11'(byte_q + 11'h001);
    assign data_first = 11'(flash_pkg::BYTE_DATA_FIRST + flash_pkg::dummy_bytes(op_q));
    // Address bytes go out most significant first
    assign next_tx = (next_byte == 11'h001) ? addr_q[23:16]
        : (next_byte == 11'h002) ? addr_q[15:8]
        : (next_byte == 11'h003) ? addr_q[7:0]
        : (next_byte >= data_first && op_q == flash_pkg::OP_BUF_WRITE) ? wdata_in : 8'h00;

    assign wdata_take_out = state_q == H_SHIFT && ph_q == flash_pkg::PH_LAST
        && bit_q == flash_pkg::BIT_LAST && next_byte != total_q
        && next_byte >= data_first && op_q == flash_pkg::OP_BUF_WRITE;
    assign busy_out = state_q != H_IDLE;
    assign link.cs_n = cs_n_q;
    assign link.sck = sck_q;
    assign link.si = si_q;

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= H_IDLE;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            ph_q <= 3'h0;
            bit_q <= 3'h0;
            byte_q <= 11'h000;
            total_q <= 11'h000;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= 24'h000000;
            rdata_out <= 8'h00;
            rdata_valid_out <= 1'b0;
        end else begin
            rdata_valid_out <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (start_in) begin
                        op_q <= opcode_in;
                        addr_q <= address_in;
                        total_q <= 11'(flash_pkg::BYTE_DATA_FIRST
                            + flash_pkg::dummy_bytes(opcode_in) + length_in);
                        tx_q <= opcode_in;
                        byte_q <= 11'h000;
                        bit_q <= 3'h0;
                        ph_q <= 3'h0;
                        cs_n_q <= 1'b0;
                        state_q <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    ph_q <= 3'(ph_q + 3'h1);
                    if (ph_q == 3'h0) begin
                        si_q <= tx_q[7];
                    end
                    if (ph_q == flash_pkg::PH_RISE) begin
                        sck_q <= 1'b1;
                    end
                    if (ph_q == flash_pkg::PH_LAST) begin
                        sck_q <= 1'b0;
                        rx_q <= {rx_q[6:0], so_s};
                        tx_q <= {tx_q[6:0], 1'b0};
                        bit_q <= 3'(bit_q + 3'h1);
                        if (bit_q == flash_pkg::BIT_LAST) begin
                            byte_q <= next_byte;
                            tx_q <= next_tx;
                            if (byte_q >= data_first && flash_pkg::is_read(op_q)) begin
                                rdata_out <= {rx_q[6:0], so_s};
                                rdata_valid_out <= 1'b1;
                            end
                            if (next_byte == total_q) begin
                                // Select rises after the last clock starts timed work
                                cs_n_q <= 1'b1;
                                ph_q <= 3'h0;
                                state_q <= H_GAP;
                            end
                        end
                    end
                end
                H_GAP: begin
                    ph_q <= 3'(ph_q + 3'h1);
                    if (ph_q == flash_pkg::CS_GAP) begin
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* flash_link_chk.sv */
// Purpose: Assertions on the serial link between host end and device end
// Assumes: Both ends run on clock_in; reset_in asynchronous, active high
// Notes: Serial clock rises are counted per frame by helper logic
`timescale 1ns/1ns
module flash_link_chk (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic sck_q;
    logic [11:0] rise_q;
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            sck_q <= 1'b0;
        end else begin
            sck_q <= sck;
        end
    end
    // Cleared while deselected, so it always holds the current frame only
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rise_q <= 12'h000;
        end else if (cs_n) begin
            rise_q <= 12'h000;
        end else if (sck && !sck_q) begin
            rise_q <= rise_q + 12'h001;
        end
    end
    default clocking dc @(posedge clock_in); endclocking
    default disable iff (reset_in);
    sequence sck_high;
        sck [*4];
    endsequence
    sequence sck_pulse;
        sck_high ##1 !sck;
    endsequence
    AST_SCK_PULSE: assert property ($rose(sck) |-> sck_pulse)
        else $error("serial clock pulse length wrong");
    AST_SCK_IN_FRAME: assert property (sck |-> !cs_n)
        else $error("serial clock outside frame");
    AST_SI_STABLE: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_q[2:0] == 3'h0)
        else $error("frame ended mid byte");
    AST_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("output not released after deselect");
    AST_IDLE_OFF: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    AST_OE_SELECTED: assert property ($rose(so_oe) |-> !cs_n)
        else $error("output enabled while deselected");
    AST_OE_AFTER_ADDR: assert property ($rose(so_oe) |-> rise_q >= 12'h028)
        else $error("output enabled before address done");
    AST_SO_STABLE: assert property (so_oe && $past(so_oe) && sck && $past(sck)
        |-> $stable(so))
        else $error("serial output moved while clock high");
endmodule

/* testbench.sv */
// Purpose: Host end and device end joined; buffer, program and erase traffic
// Assumes: 25 MHz clock, inputs driven at the falling edge, except widx, stepped at the rising edge on take
// Notes: Buffer and array are unknown until written, so every read follows a write
`timescale 1ns/1ns
module testbench;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic page_256 = 1'b0;
    logic start = 1'b0;
    logic [7:0] op = 8'h00;
    logic [23:0] addr = 24'h000000;
    logic [9:0] len = 10'h000;
    logic [7:0] wbase = 8'h00;
    logic [7:0] widx = 8'h00;
    logic take, rvalid, hbusy, dbusy;
    logic [7:0] rdata;
    logic [7:0] rq[$];
    int fails = 0;
    int total_checks = 0;
    flash_link_if link_bus();
    flash_device i_flash_device (.clock_in(clock_in), .reset_in(reset_in), .link(link_bus),
        .page_256_in(page_256), .busy_out(dbusy));
    flash_host i_flash_host (.clock_in(clock_in), .reset_in(reset_in), .link(link_bus),
        .start_in(start), .opcode_in(op), .address_in(addr), .length_in(len),
        .wdata_in(8'(wbase + widx)), .wdata_take_out(take), .rdata_out(rdata),
        .rdata_valid_out(rvalid), .busy_out(hbusy));
    flash_link_chk chk (.clock_in(clock_in), .reset_in(reset_in), .cs_n(link_bus.cs_n),
        .sck(link_bus.sck), .si(link_bus.si), .so(link_bus.so), .so_oe(link_bus.so_oe));
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        if (take === 1'b1) widx <= widx + 8'h01;
        if (rvalid === 1'b1) rq.push_back(rdata);
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Waits for the host frame, and for the device job too when wd is set
    task automatic run(input logic [7:0] o, input logic [23:0] a, input logic [9:0] n,
        input logic wd);
        int k;
        @(negedge clock_in);
        op = o; addr = a; len = n; start = 1'b1; widx = 8'h00; rq.delete();
        @(negedge clock_in);
        start = 1'b0;
        for (k = 0; k < 20000; k++) begin
            @(negedge clock_in);
            if (hbusy === 1'b0 && (dbusy === 1'b0 || !wd)) break;
        end
        if (k == 20000) begin
            fails++;
            finish_test();
        end
    endtask
    task automatic expect_q(input int n, input logic [7:0] first, input logic [7:0] step);
        for (int i = 0; i < n; i++) check(rq.size() > i ? rq[i] : 8'hXX, 8'(first + step * i));
    endtask
    task automatic t_buffer_wrap();
        wbase = 8'hA0;
        run(8'h84, 24'h000105, 10'h006, 1'b1);
        run(8'hD4, 24'hFFFF05, 10'h006, 1'b1);
        expect_q(6, 8'hA0, 8'h01);
        run(8'hD1, 24'h000000, 10'h003, 1'b1);
        expect_q(3, 8'hA3, 8'h01);
    endtask
    task automatic t_program_erase();
        wbase = 8'h10;
        run(8'h84, 24'h000000, 10'h108, 1'b1);
        run(8'h83, 24'h000A00, 10'h000, 1'b1);
        run(8'hD2, 24'h000B06, 10'h004, 1'b1);
        expect_q(2, 8'h16, 8'h01);
        check(rq[2], 8'h10);
        run(8'hD4, 24'h000106, 10'h002, 1'b1);
        expect_q(2, 8'h16, 8'h01);
        run(8'h81, 24'h000A00, 10'h000, 1'b1);
        run(8'hD2, 24'h000A00, 10'h003, 1'b1);
        expect_q(3, 8'hFF, 8'h00);
        run(8'h88, 24'h000A00, 10'h000, 1'b1);
        run(8'hD2, 24'h000A00, 10'h003, 1'b1);
        expect_q(3, 8'h10, 8'h01);
        run(8'h50, 24'h000FFF, 10'h000, 1'b1);
        run(8'hD2, 24'h000A05, 10'h002, 1'b1);
        expect_q(2, 8'hFF, 8'h00);
    endtask
    task automatic t_busy_refuse();
        run(8'h50, 24'h001200, 10'h000, 1'b0);
        check({7'h00, dbusy}, 8'h01);
        wbase = 8'h77;
        run(8'h84, 24'h000000, 10'h002, 1'b1);
        run(8'hD4, 24'h000000, 10'h002, 1'b1);
        expect_q(2, 8'h10, 8'h01);
    endtask
    task automatic t_page_256();
        @(negedge clock_in);
        page_256 = 1'b1;
        wbase = 8'hC0;
        run(8'h84, 24'h0000FE, 10'h003, 1'b1);
        run(8'hD4, 24'hFFFFFE, 10'h003, 1'b1);
        expect_q(3, 8'hC0, 8'h01);
        // Address 0x000900 is page 9, in block 1, only under the 256 layout
        run(8'h81, 24'h000900, 10'h000, 1'b1);
        run(8'h88, 24'h000900, 10'h000, 1'b1);
        run(8'hD2, 24'h0009FF, 10'h003, 1'b1);
        expect_q(2, 8'hC1, 8'h01);
        check(rq[2], 8'h11);
        run(8'h50, 24'h000800, 10'h000, 1'b1);
        run(8'hD2, 24'h000900, 10'h002, 1'b1);
        expect_q(2, 8'hFF, 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge clock_in);
        reset_in = 1'b0;
        repeat (4) @(negedge clock_in);
        t_buffer_wrap();
        t_program_erase();
        t_busy_refuse();
        t_page_256();
        finish_test();
    end
endmodule
